// ---- core/quad_mux_pkg.sv ----
// shared constants, types and baud table for the four-line serial multiplexer
package quad_mux_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int NUM_LINES = 4;
    // bottom entry of the silo stays hidden this long after a pop
    localparam int MOVE_DOWN_NS = 1000;
    localparam int MOVE_DOWN_CYC = (MOVE_DOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] SETTLE_CYC = 6'(MOVE_DOWN_CYC);
    localparam int SILO_DEPTH = 16;
    localparam int SILO_AW = 4;
    localparam logic [SILO_AW:0] SILO_FULL = 5'(SILO_DEPTH);

    // register word indices
    localparam logic [1:0] REG_CSR = 2'h0;
    localparam logic [1:0] REG_RXBUF = 2'h1;
    localparam logic [1:0] REG_TCR = 2'h2;
    localparam logic [1:0] REG_TDR = 2'h3;

    // control_status_reg fields
    localparam int CSR_CLR_BIT = 4;
    localparam int CSR_MSE_BIT = 5;
    localparam int CSR_RIE_BIT = 6;
    localparam int CSR_RDONE_BIT = 7;
    localparam int CSR_TRANSMIT_LINE_FIELD_LSB = 8;
    localparam int CSR_TIE_BIT = 14;
    localparam int CSR_TRANSMITTER_READY_BIT = 15;
    // receive_silo_read_reg fields
    localparam int RX_LINE_LSB = 8;
    localparam int RX_VALID_BIT = 15;
    // line_param_reg fields
    localparam int LP_LINE_LSB = 0;
    localparam int LP_LEN_LSB = 3;
    localparam int LP_STOP_BIT = 5;
    localparam int LP_PAREN_BIT = 6;
    localparam int LP_ODD_BIT = 7;
    localparam int LP_SPEED_LSB = 8;
    // transmit_control_reg, transmit_data_reg, modem_status_reg fields
    localparam int TCR_EN_LSB = 0;
    localparam int TCR_DTR_LSB = 8;
    localparam int TDR_BRK_LSB = 8;
    localparam int MSR_RING_LSB = 0;
    localparam int MSR_CARR_LSB = 8;

    // reset values and interrupt vectors
    localparam logic [3:0] LINE_EN_RST = 4'h0;
    localparam logic [3:0] DTR_RST = 4'h0;
    localparam logic [3:0] BRK_RST = 4'h0;
    localparam logic [2:0] IRQ_VEC_RX = 3'h0;
    localparam logic [2:0] IRQ_VEC_TX = 3'h4;

    typedef struct packed {
        logic [3:0] speed;
        logic par_odd;
        logic par_en;
        logic stop2;
        logic [1:0] len;
    } line_cfg_t;

    typedef struct packed {
        logic [1:0] line;
        logic [7:0] data;
    } rx_char_t;

    localparam line_cfg_t CFG_RST = line_cfg_t'(9'h000);

    // clock cycles per bit; zero marks the unused code
    function automatic logic [19:0] baud_div(input logic [3:0] code);
        case (code)
            4'h0: baud_div = 20'(CLK_HZ / 50);
            4'h1: baud_div = 20'(CLK_HZ / 75);
            4'h2: baud_div = 20'(CLK_HZ / 110);
            4'h3: baud_div = 20'(CLK_HZ * 2 / 269);
            4'h4: baud_div = 20'(CLK_HZ / 150);
            4'h5: baud_div = 20'(CLK_HZ / 300);
            4'h6: baud_div = 20'(CLK_HZ / 600);
            4'h7: baud_div = 20'(CLK_HZ / 1200);
            4'h8: baud_div = 20'(CLK_HZ / 1800);
            4'h9: baud_div = 20'(CLK_HZ / 2000);
            4'ha: baud_div = 20'(CLK_HZ / 2400);
            4'hb: baud_div = 20'(CLK_HZ / 3600);
            4'hc: baud_div = 20'(CLK_HZ / 4800);
            4'hd: baud_div = 20'(CLK_HZ / 7200);
            4'he: baud_div = 20'(CLK_HZ / 9600);
            default: baud_div = 20'h00000;
        endcase
    endfunction : baud_div
endpackage : quad_mux_pkg

// ---- core/rx_silo.sv ----
// shared receive silo with pop-on-read and move-down delay
module rx_silo import quad_mux_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_flush,
    input wire logic i_push,
    input rx_char_t i_push_data,
    input wire logic i_pop,
    // bottom entry
    output rx_char_t o_bottom,
    output logic o_bottom_valid
);
    rx_char_t mem_ff [SILO_DEPTH];
    rx_char_t nxt_mem [SILO_DEPTH];
    logic [SILO_AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic [SILO_AW:0] count_ff, nxt_count;
    logic [5:0] settle_ff, nxt_settle;
    logic do_push, do_pop;

    assign o_bottom = mem_ff[rd_ptr_ff];
    assign o_bottom_valid = (count_ff != '0) && (settle_ff == 6'h00); // RL4
    assign do_pop = i_pop && o_bottom_valid;
    // characters arriving while full are dropped
    assign do_push = i_push && (count_ff != SILO_FULL);

    always_comb begin
        nxt_mem = mem_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count = count_ff;
        nxt_settle = (settle_ff != 6'h00) ? settle_ff - 6'h01 : settle_ff;
        if (do_push) begin
            nxt_mem[wr_ptr_ff] = i_push_data;
            nxt_wr_ptr = wr_ptr_ff + 4'h1;
        end
        if (do_pop) begin
            nxt_rd_ptr = rd_ptr_ff + 4'h1; // RL1
            nxt_settle = SETTLE_CYC; // RL4
        end
        if (do_push && !do_pop) begin
            nxt_count = count_ff + 5'h01;
        end else if (do_pop && !do_push) begin
            nxt_count = count_ff - 5'h01;
        end
        if (i_flush) begin
            nxt_wr_ptr = '0;
            nxt_rd_ptr = '0;
            nxt_count = '0;
            nxt_settle = 6'h00;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            for (int i = 0; i < SILO_DEPTH; i++) begin
                mem_ff[i] <= rx_char_t'(10'h000);
            end
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            settle_ff <= 6'h00;
        end else begin
            mem_ff <= nxt_mem;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            settle_ff <= nxt_settle;
        end
    end

    a_pop_advances: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL3
        (i_pop && o_bottom_valid && !i_push && !i_flush) |=> (count_ff == $past(count_ff) - 5'h01))
        else $error("silo did not advance on read");
    a_move_down_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL4
        (do_pop && !i_flush) |=> !o_bottom_valid [*8])
        else $error("next entry visible too soon after pop");
endmodule : rx_silo

// ---- core/line_tx.sv ----
// one double-buffered serial transmitter with break forcing
module line_tx import quad_mux_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // control
    input wire logic i_clear,
    input line_cfg_t i_cfg,
    input wire logic i_load,
    input wire logic [7:0] i_char,
    input wire logic i_break,
    // status and line
    output logic o_buf_empty,
    output logic o_txd
);
    logic [19:0] div_ff, nxt_div;
    logic [7:0] hold_ff, nxt_hold;
    logic hold_full_ff, nxt_hold_full;
    logic [11:0] shift_ff, nxt_shift;
    logic [3:0] bits_ff, nxt_bits;
    logic txd_ff, nxt_txd;
    logic [11:0] frame;
    logic [3:0] nlen;
    logic par;
    logic [19:0] rate;

    assign o_buf_empty = !hold_full_ff;
    assign o_txd = txd_ff;
    assign rate = baud_div(i_cfg.speed);
    assign nlen = 4'h5 + {2'b00, i_cfg.len};

    always_comb begin
        frame = 12'hfff;
        frame[0] = 1'b0;
        par = i_cfg.par_odd;
        for (int i = 0; i < 8; i++) begin
            if (4'(i) < nlen) begin
                frame[1 + i] = hold_ff[i];
                par = par ^ hold_ff[i];
            end
        end
        if (i_cfg.par_en) begin
            frame[4'h1 + nlen] = par;
        end
    end

    always_comb begin
        nxt_div = div_ff;
        nxt_hold = hold_ff;
        nxt_hold_full = hold_full_ff;
        nxt_shift = shift_ff;
        nxt_bits = bits_ff;
        // break only masks the pin; the shifter keeps draining the buffer
        if (bits_ff != 4'h0) begin // RL15
            if (div_ff == 20'h00000) begin
                nxt_shift = {1'b1, shift_ff[11:1]};
                nxt_bits = bits_ff - 4'h1;
                nxt_div = rate - 20'h00001;
            end else begin
                nxt_div = div_ff - 20'h00001;
            end
        end else if (hold_full_ff && rate != 20'h00000) begin
            nxt_shift = frame;
            nxt_bits = 4'h2 + nlen + {3'b000, i_cfg.par_en} + {3'b000, i_cfg.stop2};
            nxt_div = rate - 20'h00001;
            nxt_hold_full = 1'b0;
        end
        if (i_load) begin
            nxt_hold = i_char;
            nxt_hold_full = 1'b1;
        end
        if (i_clear) begin
            nxt_div = 20'h00000;
            nxt_hold_full = 1'b0;
            nxt_bits = 4'h0;
            nxt_shift = 12'hfff;
        end
        if (i_break) begin
            nxt_txd = 1'b0; // RL14
        end else begin
            nxt_txd = (nxt_bits != 4'h0) ? nxt_shift[0] : 1'b1; // RL13
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            div_ff <= 20'h00000;
            hold_ff <= 8'h00;
            hold_full_ff <= 1'b0;
            shift_ff <= 12'hfff;
            bits_ff <= 4'h0;
            txd_ff <= 1'b1;
        end else begin
            div_ff <= nxt_div;
            hold_ff <= nxt_hold;
            hold_full_ff <= nxt_hold_full;
            shift_ff <= nxt_shift;
            bits_ff <= nxt_bits;
            txd_ff <= nxt_txd;
        end
    end

    a_break_low: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL14
        i_break |=> !o_txd)
        else $error("line not held low during break");
    a_idle_mark: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL13
        (bits_ff == 4'h0 && !hold_full_ff && !i_break) |=> o_txd)
        else $error("idle line not at one");
endmodule : line_tx

// ---- core/quad_async_mux_tx_scan_modem.sv ----
// four-line serial multiplexer: silo reads, transmit scanner, break and modem control
//
// Overview of operation
// (RL1) receive read returns bottom entry, then pops
// (RL2) every receive word carries data-valid flag
// (RL3) any receive read pops the silo
// (RL4) successive receive reads one microsecond apart
// (RL5) host sets formats and scan enable first
// (RL6) line enables writable by word or byte
// (RL7) scanner seeks enabled lines with empty buffer
// (RL8) found line: set line field, ready, request
// (RL9) char load or enable clear drops ready
// (RL10) line 3 highest priority, line 0 lowest
// (RL11) host loads only for indicated line
// (RL12) host stops line by clearing enable
// (RL13) idle serial output sits at one
// (RL14) break bit holds output at zero
// (RL15) scanner keeps serving lines under break
// (RL16) host brackets break with all-zero characters
// (RL17) terminal-ready bits drive outputs directly
// (RL18) terminal-ready cleared by reset, not clear
// (RL19) carrier and ring bits read live, read-only
// (RL20) modem input changes raise no interrupt
// (RL21) modem logic independent of receive, transmit
// (RL22) ready at bit 15, receive wins ties
// (RL23) each request gated by its own enable
// (RL24) scanner idle while scan enable clear
//
// Added by the designer: the register offsets and the address-and-strobe port.
module quad_async_mux_tx_scan_modem import quad_mux_pkg::*; (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // register port
    input wire logic [1:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [1:0] i_byte_en,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // characters from the receivers
    input wire logic i_rx_valid,
    input rx_char_t i_rx_char,
    // serial outputs
    output logic [NUM_LINES-1:0] o_txd,
    // modem signals
    output logic [NUM_LINES-1:0] o_term_ready,
    input wire logic [NUM_LINES-1:0] i_carrier_in,
    input wire logic [NUM_LINES-1:0] i_ring_in,
    // interrupt request
    output logic o_irq_req,
    output logic [2:0] o_irq_vector
);
    logic mse_ff, nxt_mse, rie_ff, nxt_rie, tie_ff, nxt_tie, transmitter_ready_ff, nxt_transmitter_ready;
    logic [1:0] transmit_line_field_ff, nxt_transmit_line_field;
    logic [NUM_LINES-1:0] line_en_ff, nxt_line_en, dtr_ff, nxt_dtr, brk_ff, nxt_brk;
    line_cfg_t cfg_ff [NUM_LINES];
    line_cfg_t nxt_cfg [NUM_LINES];
    logic [NUM_LINES-1:0] carr_s1_ff, carr_s2_ff, ring_s1_ff, ring_s2_ff;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [NUM_LINES-1:0] buf_empty, eligible;
    logic [1:0] pick;
    logic found, sw_clear, char_wr, silo_pop, silo_valid, rx_req, tx_req;
    logic [1:0] lp_line;
    rx_char_t silo_bottom;

    assign sw_clear = i_wr && i_addr == REG_CSR && i_byte_en[0] && i_wdata[CSR_CLR_BIT];
    assign char_wr = i_wr && i_addr == REG_TDR && i_byte_en[0];
    // any read strobe at the receive buffer word pops a visible bottom entry, so test reads lose the character too
    assign silo_pop = i_rd && i_addr == REG_RXBUF; // RL3
    assign lp_line = i_wdata[LP_LINE_LSB +: 2];

    rx_silo u_silo (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_flush(sw_clear),
        .i_push(i_rx_valid),
        .i_push_data(i_rx_char),
        .i_pop(silo_pop),
        .o_bottom(silo_bottom),
        .o_bottom_valid(silo_valid)
    );

    for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
        line_tx u_tx (
            .i_core_clk(i_core_clk),
            .i_rstn(i_rstn),
            .i_clear(sw_clear),
            .i_cfg(cfg_ff[g]),
            .i_load(char_wr && transmit_line_field_ff == 2'(g)),
            .i_char(i_wdata[7:0]),
            .i_break(brk_ff[g]),
            .o_buf_empty(buf_empty[g]),
            .o_txd(o_txd[g])
        );
    end

    // scanner search, later lines overwrite so the highest wins
    always_comb begin
        eligible = line_en_ff & buf_empty; // RL7
        found = |eligible;
        pick = 2'h0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (eligible[i]) begin
                pick = 2'(i); // RL10
            end
        end
    end

    // control and scanner state
    always_comb begin
        nxt_mse = mse_ff;
        nxt_rie = rie_ff;
        nxt_tie = tie_ff;
        nxt_transmitter_ready = transmitter_ready_ff;
        nxt_transmit_line_field = transmit_line_field_ff;
        if (i_wr && i_addr == REG_CSR && i_byte_en[0]) begin
            nxt_mse = i_wdata[CSR_MSE_BIT];
            nxt_rie = i_wdata[CSR_RIE_BIT];
        end
        if (i_wr && i_addr == REG_CSR && i_byte_en[1]) begin
            nxt_tie = i_wdata[CSR_TIE_BIT];
        end
        if (transmitter_ready_ff && (char_wr || !nxt_line_en[transmit_line_field_ff])) begin
            nxt_transmitter_ready = 1'b0; // RL9
        end else if (!transmitter_ready_ff && mse_ff && found) begin
            nxt_transmitter_ready = 1'b1; // RL8
            nxt_transmit_line_field = pick; // RL8
        end
        if (!nxt_mse) begin
            nxt_transmitter_ready = 1'b0; // RL24
        end
        if (sw_clear) begin
            nxt_mse = 1'b0;
            nxt_rie = 1'b0;
            nxt_tie = 1'b0;
            nxt_transmitter_ready = 1'b0;
            nxt_transmit_line_field = 2'h0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mse_ff <= 1'b0;
            rie_ff <= 1'b0;
            tie_ff <= 1'b0;
            transmitter_ready_ff <= 1'b0;
            transmit_line_field_ff <= 2'h0;
        end else begin
            mse_ff <= nxt_mse;
            rie_ff <= nxt_rie;
            tie_ff <= nxt_tie;
            transmitter_ready_ff <= nxt_transmitter_ready;
            transmit_line_field_ff <= nxt_transmit_line_field;
        end
    end

    // line enables, terminal ready, break and line parameters
    always_comb begin
        nxt_line_en = line_en_ff;
        nxt_dtr = dtr_ff;
        nxt_brk = brk_ff;
        nxt_cfg = cfg_ff;
        if (i_wr && i_addr == REG_TCR && i_byte_en[0]) begin
            nxt_line_en = i_wdata[TCR_EN_LSB +: NUM_LINES]; // RL6
        end
        // no interlock with the scanner or silo
        if (i_wr && i_addr == REG_TCR && i_byte_en[1]) begin
            nxt_dtr = i_wdata[TCR_DTR_LSB +: NUM_LINES]; // RL17 RL21
        end
        if (i_wr && i_addr == REG_TDR && i_byte_en[1]) begin
            nxt_brk = i_wdata[TDR_BRK_LSB +: NUM_LINES]; // RL14
        end
        if (i_wr && i_addr == REG_RXBUF && i_byte_en[0]) begin
            nxt_cfg[lp_line].len = i_wdata[LP_LEN_LSB +: 2];
            nxt_cfg[lp_line].stop2 = i_wdata[LP_STOP_BIT];
            nxt_cfg[lp_line].par_en = i_wdata[LP_PAREN_BIT];
            nxt_cfg[lp_line].par_odd = i_wdata[LP_ODD_BIT];
        end
        if (i_wr && i_addr == REG_RXBUF && i_byte_en[1]) begin
            nxt_cfg[lp_line].speed = i_wdata[LP_SPEED_LSB +: 4];
        end
        // terminal ready survives a software clear
        if (sw_clear) begin
            nxt_line_en = LINE_EN_RST;
            nxt_brk = BRK_RST; // RL18
            for (int i = 0; i < NUM_LINES; i++) begin
                nxt_cfg[i] = CFG_RST;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            line_en_ff <= LINE_EN_RST;
            dtr_ff <= DTR_RST; // RL18
            brk_ff <= BRK_RST;
            for (int i = 0; i < NUM_LINES; i++) begin
                cfg_ff[i] <= CFG_RST;
            end
        end else begin
            line_en_ff <= nxt_line_en;
            dtr_ff <= nxt_dtr;
            brk_ff <= nxt_brk;
            cfg_ff <= nxt_cfg;
        end
    end

    // modem inputs are pins, two flops before use
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            carr_s1_ff <= '0;
            carr_s2_ff <= '0;
            ring_s1_ff <= '0;
            ring_s2_ff <= '0;
        end else begin
            carr_s1_ff <= i_carrier_in;
            carr_s2_ff <= carr_s1_ff;
            ring_s1_ff <= i_ring_in;
            ring_s2_ff <= ring_s1_ff;
        end
    end

    // read data stand only in the cycle after the strobe
    always_comb begin
        nxt_rdata = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                REG_CSR: begin
                    nxt_rdata[CSR_MSE_BIT] = mse_ff;
                    nxt_rdata[CSR_RIE_BIT] = rie_ff;
                    nxt_rdata[CSR_RDONE_BIT] = silo_valid;
                    nxt_rdata[CSR_TRANSMIT_LINE_FIELD_LSB +: 2] = transmit_line_field_ff;
                    nxt_rdata[CSR_TIE_BIT] = tie_ff;
                    nxt_rdata[CSR_TRANSMITTER_READY_BIT] = transmitter_ready_ff; // RL22
                end
                REG_RXBUF: begin
                    if (silo_valid) begin
                        nxt_rdata[7:0] = silo_bottom.data; // RL1
                        nxt_rdata[RX_LINE_LSB +: 2] = silo_bottom.line;
                        nxt_rdata[RX_VALID_BIT] = 1'b1; // RL2
                    end
                end
                REG_TCR: begin
                    nxt_rdata[TCR_EN_LSB +: NUM_LINES] = line_en_ff;
                    nxt_rdata[TCR_DTR_LSB +: NUM_LINES] = dtr_ff;
                end
                REG_TDR: begin
                    nxt_rdata[MSR_RING_LSB +: NUM_LINES] = ring_s2_ff; // RL19
                    nxt_rdata[MSR_CARR_LSB +: NUM_LINES] = carr_s2_ff; // RL19
                end
                default: begin
                    nxt_rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_term_ready = dtr_ff; // RL17
    assign rx_req = rie_ff && silo_valid; // RL23
    assign tx_req = tie_ff && transmitter_ready_ff; // RL8 RL23
    // modem inputs take no part in the request
    assign o_irq_req = rx_req || tx_req; // RL20
    assign o_irq_vector = rx_req ? IRQ_VEC_RX : IRQ_VEC_TX; // RL22

    a_scan_sets_ready: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL8
        (mse_ff && nxt_mse && !transmitter_ready_ff && found && !sw_clear)
        |=> (transmitter_ready_ff && transmit_line_field_ff == $past(pick)))
        else $error("scanner missed an eligible line");
    a_load_drops_ready: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL9
        (transmitter_ready_ff && char_wr) |=> !transmitter_ready_ff)
        else $error("ready not cleared by character load");
    a_top_priority: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL10
        (mse_ff && nxt_mse && !transmitter_ready_ff && eligible[3] && !sw_clear) |=> (transmit_line_field_ff == 2'h3))
        else $error("line 3 not served first");
    a_scan_disabled: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL24
        !mse_ff |-> !transmitter_ready_ff)
        else $error("ready set with scan disabled");
    a_empty_flag: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL2
        (silo_pop && !silo_valid) |=> !o_rdata[RX_VALID_BIT])
        else $error("valid flag set on empty silo");
    a_read_pops: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL1
        (silo_pop && silo_valid)
        |=> (o_rdata[RX_VALID_BIT] && o_rdata[7:0] == $past(silo_bottom.data) && !silo_valid))
        else $error("receive read did not return and pop bottom");
    a_ready_keep_clear: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL18
        sw_clear |=> (o_term_ready == $past(dtr_ff)))
        else $error("terminal ready lost on software clear");
    a_ready_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn) // RL17
        (i_wr && i_addr == REG_TCR && i_byte_en[1])
        |=> (o_term_ready == $past(i_wdata[TCR_DTR_LSB +: NUM_LINES])))
        else $error("terminal ready not following write");
endmodule : quad_async_mux_tx_scan_modem

// ---- bench/host.sv ----
// host processor model driving the register port
module host (
    // clock
    input wire logic i_core_clk,
    // register port
    output logic [1:0] o_addr,
    output logic [15:0] o_wdata,
    output logic [1:0] o_byte_en,
    output logic o_wr,
    output logic o_rd,
    input wire logic [15:0] i_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_addr = 2'h0;
        o_wdata = 16'h0000;
        o_byte_en = 2'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // callers pick line, format and scan setup themselves
    task automatic wr(input logic [1:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge i_core_clk);
        o_addr <= a;
        o_wdata <= d;
        o_byte_en <= be;
        o_wr <= 1'b1;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
        // released data bus must not keep the old word
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask : rd
endmodule : host

// ---- bench/test_quad_async_mux_tx_scan_modem.sv ----
// self-checking bench for the four-line multiplexer
module test_quad_async_mux_tx_scan_modem;
    timeunit 1ns;
    timeprecision 1ps;
    import quad_mux_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rx_valid = 1'b0;
    rx_char_t rx_char = '0;
    logic [3:0] carrier = 4'h0;
    logic [3:0] ring = 4'h0;
    logic [1:0] addr, be;
    logic [15:0] wdata, rdata;
    logic wr, rd, irq;
    logic [3:0] txd, dtr;
    logic [2:0] vec;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    initial begin
        forever #12.5 clk = ~clk;
    end
    quad_async_mux_tx_scan_modem u_quad_async_mux_tx_scan_modem (
        .i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_byte_en(be),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_valid(rx_valid), .i_rx_char(rx_char),
        .o_txd(txd), .o_term_ready(dtr), .i_carrier_in(carrier), .i_ring_in(ring),
        .o_irq_req(irq), .o_irq_vector(vec));
    host u_host (.i_core_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_byte_en(be),
        .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic push(input logic [7:0] ch);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_char <= {2'h2, ch};
        @(posedge clk);
        rx_valid <= 1'b0;
    endtask : push
    task automatic t_silo();
        logic [15:0] d;
        push(8'h5a);
        push(8'h3c);
        push(8'ha5);
        repeat (45) @(posedge clk);
        u_host.wr(REG_CSR, 16'h0040, 2'h1);
        #1;
        chk("rx irq", {12'h0, irq, vec}, 16'h0008);
        u_host.rd(REG_RXBUF, d);
        chk("rx first", d, 16'h825a);
        // too soon after a pop: false empty, nothing popped
        u_host.rd(REG_RXBUF, d);
        chk("rx too soon", 16'(d[15]), 16'h0000);
        repeat (40) @(posedge clk);
        // discarded read still pops the middle entry
        u_host.rd(REG_RXBUF, d);
        repeat (40) @(posedge clk);
        u_host.rd(REG_RXBUF, d);
        chk("rx third", d, 16'h82a5);
        repeat (40) @(posedge clk);
        u_host.rd(REG_RXBUF, d);
        chk("rx empty", {15'h0, d[15]}, 16'h0000);
    endtask : t_silo
    task automatic t_scan();
        logic [15:0] d;
        u_host.wr(REG_RXBUF, 16'h0e1b, 2'h3);
        // speed code 15 parks line 1 characters in its buffer
        u_host.wr(REG_RXBUF, 16'h0f01, 2'h3);
        u_host.wr(REG_TCR, 16'h000a, 2'h3);
        u_host.wr(REG_CSR, 16'h4020, 2'h3);
        u_host.rd(REG_CSR, d);
        chk("csr line3", d, 16'hc320);
        chk("irq", {12'h0, irq, vec}, 16'h000c);
        u_host.wr(REG_TDR, 16'h0055, 2'h1);
        repeat (3) @(posedge clk);
        #1;
        chk("start bit", 16'(txd[3]), 16'h0000);
        u_host.wr(REG_TDR, 16'h0200, 2'h2);
        u_host.rd(REG_CSR, d);
        chk("csr line1", d, 16'hc120);
        chk("break", 16'(txd[1]), 16'h0000);
        // line 1 takes a character under break, then line 3 is served again
        u_host.wr(REG_TDR, 16'h0000, 2'h1);
        u_host.rd(REG_CSR, d);
        chk("csr line3 again", d, 16'hc320);
        u_host.wr(REG_TCR, 16'h0002, 2'h1);
        u_host.rd(REG_CSR, d);
        chk("ready drop", 16'(d[15]), 16'h0000);
        u_host.wr(REG_TDR, 16'h0000, 2'h2);
        repeat (2) @(posedge clk);
        #1;
        chk("break off", 16'(txd[1]), 16'h0001);
        u_host.wr(REG_CSR, 16'h4000, 2'h3);
        u_host.wr(REG_TCR, 16'h000a, 2'h1);
        u_host.rd(REG_CSR, d);
        chk("scan off", {14'h0, d[15:14]}, 16'h0001);
        chk("no irq", 16'(irq), 16'h0000);
    endtask : t_scan
    task automatic t_modem();
        logic [15:0] d;
        u_host.wr(REG_TCR, 16'h0500, 2'h2);
        u_host.rd(REG_TCR, d);
        chk("tcr", d, 16'h050a);
        chk("dtr", 16'(dtr), 16'h0005);
        @(posedge clk);
        carrier <= 4'h9;
        ring <= 4'h6;
        repeat (4) @(posedge clk);
        u_host.rd(REG_TDR, d);
        chk("modem", d, 16'h0906);
        chk("modem irq", 16'(irq), 16'h0000);
        u_host.wr(REG_CSR, 16'h0010, 2'h1);
        #1;
        chk("dtr clr", 16'(dtr), 16'h0005);
        @(posedge clk);
        rstn <= 1'b0;
        #1;
        chk("dtr rst", 16'(dtr), 16'h0000);
    endtask : t_modem
    // generous ceiling; the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        chk("txd idle", 16'(txd), 16'h000f);
        t_silo();
        t_scan();
        t_modem();
        close_out();
    end
endmodule : test_quad_async_mux_tx_scan_modem
